// ### verilog/lvs_pkg.sv
// Shared constants, types and helpers of the seven-to-one serializer.
// Assumes a 50 MHz system clock that oversamples the strobe clock pin.
package lvs_pkg;

    // ****************************************
    // Widths and layout
    // ****************************************
    localparam int WORD_W = 21;
    localparam int LANES = 3;
    localparam int SLOTS = 7;
    localparam int FIFO_DEPTH = 16;
    localparam int PCNT_W = 8;
    localparam int LOCK_CNT_W = 20;
    localparam logic [PCNT_W-1:0] PCNT_MAX = 8'hFF;
    localparam logic [2:0] SLOT_FIRST = 3'h0;
    localparam logic [2:0] SLOT_LAST = 3'h6;
    localparam logic [2:0] FCLK_HIGH_SLOTS = 3'h4;
    localparam logic [PCNT_W-1:0] SLOT_STEP = 8'h07;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 20;
    localparam int PLL_LOCK_TIME_MS = 10;
    localparam int PLL_LOCK_CYC = (PLL_LOCK_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POWERDOWN_DELAY_US = 100;
    localparam int POWERDOWN_DELAY_CYC = (POWERDOWN_DELAY_US * 1000) / CLK_PERIOD_NS;
    localparam int STROBE_PERIOD_MIN_PS = 13300;
    localparam int STROBE_PERIOD_MAX_PS = 66700;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        ST_DOWN = 3'b001,
        ST_ACQ  = 3'b010,
        ST_LOCK = 3'b100
    } lvs_state_e;

    typedef struct packed {
        logic [LANES-1:0] lane_p;
        logic [LANES-1:0] lane_n;
        logic clk_p;
        logic clk_n;
        logic oe;
    } lvs_lvds_s;

    typedef struct packed {
        logic strobe;
        logic pwr_n;
        logic [WORD_W-1:0] word;
    } lvs_pins_s;

    // Seven bits of one lane out of the parallel word
    function automatic logic [SLOTS-1:0] lvs_lane_bits(input logic [WORD_W-1:0] w, input int l);
        lvs_lane_bits = w[l*SLOTS +: SLOTS];
    endfunction

endpackage

// ### verilog/lvs_sync.sv
// Three-stage synchroniser for pin inputs.
// Assumes the inputs are asynchronous to clk; stage one feeds only stage two.
`timescale 1ns/1ps
module lvs_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q2,
    output logic [W-1:0] q3
);
    import lvs_pkg::*;

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
    } lvs_sync_s;

    lvs_sync_s q_r;
    lvs_sync_s q_nxt;

    always_comb begin
        q_nxt = q_r;
        if (ce) begin
            q_nxt.s1 = d;
            q_nxt.s2 = q_r.s1;
            q_nxt.s3 = q_r.s2;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign q2 = q_r.s2;
    assign q3 = q_r.s3;
endmodule

// ### verilog/lvs_fifo.sv
// Word FIFO between strobe capture and the lane shifters.
// Assumes both sides on clk; in_ready and out_valid are combinational.
`timescale 1ns/1ps
module lvs_fifo #(
    parameter int W = 21,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    import lvs_pkg::*;

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] wptr;
        logic [AW:0] rptr;
    } lvs_fifo_s;

    lvs_fifo_s q_r;
    lvs_fifo_s q_nxt;
    logic [W-1:0] mem [DEPTH];
    logic full;
    logic empty;
    logic push;
    logic pop;

    assign empty = (q_r.wptr == q_r.rptr);
    assign full = (q_r.wptr[AW] != q_r.rptr[AW]) && (q_r.wptr[AW-1:0] == q_r.rptr[AW-1:0]);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[q_r.rptr[AW-1:0]];
    assign push = ce && in_valid && !full;
    assign pop = ce && out_ready && !empty;

    always_comb begin
        q_nxt = q_r;
        if (push) begin
            q_nxt.wptr = q_r.wptr + 1'b1;
        end
        if (pop) begin
            q_nxt.rptr = q_r.rptr + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[q_r.wptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end
endmodule

// ### verilog/lvs_serializer.sv
// Seven-to-one serializer: 21-bit word onto three lanes plus forwarded clock.
// Assumes a 50 MHz clk that oversamples the strobe pin; all pins are async.
`timescale 1ns/1ps
module lvs_serializer #(
    parameter int LOCK_CYCLES = lvs_pkg::PLL_LOCK_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic strobe_clock_in,
    input wire logic power_down_n,
    input wire logic [lvs_pkg::WORD_W-1:0] parallel_word_in,
    input wire logic [lvs_pkg::WORD_W-1:0] parallel_word_float,
    output lvs_pkg::lvs_lvds_s lvds_out,
    output logic word_ready,
    output logic pll_locked
);
    import lvs_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        lvs_state_e st;
        logic strobe_lvl;
        logic pwr_lvl;
        logic [PCNT_W-1:0] pcnt;
        logic [PCNT_W-1:0] period;
        logic [PCNT_W-1:0] acc;
        logic [2:0] slot;
        logic [LANES-1:0][SLOTS-1:0] shreg;
        logic [LOCK_CNT_W-1:0] lock_cnt;
        logic [LANES-1:0] lane;
        logic fclk;
        logic oe;
    } lvs_core_s;

    lvs_core_s q_r;
    lvs_core_s q_nxt;

    lvs_pins_s pins;
    lvs_pins_s pins_q2;
    lvs_pins_s pins_q3;
    logic rise;
    logic push;
    logic pop;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [WORD_W-1:0] fifo_dout;
    logic [PCNT_W-1:0] acc_sum;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    always_comb begin
        pins.strobe = strobe_clock_in;
        pins.pwr_n = power_down_n;
        pins.word = parallel_word_in | parallel_word_float;
    end

    lvs_sync #(
        .W($bits(lvs_pins_s))
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .d(pins),
        .q2(pins_q2),
        .q3(pins_q3)
    );

    // Rising strobe once stages two and three agree high
    assign rise = (pins_q2.strobe == pins_q3.strobe) && pins_q3.strobe && !q_r.strobe_lvl;
    assign push = rise;
    assign pop = rise && q_r.pwr_lvl && fifo_out_valid;

    // ****************************************
    // Word buffer
    // ****************************************
    lvs_fifo #(
        .W(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data(pins_q3.word),
        .out_valid(fifo_out_valid),
        .out_ready(pop),
        .out_data(fifo_dout)
    );

    // ****************************************
    // Next state
    // ****************************************
    assign acc_sum = q_r.acc + SLOT_STEP;

    always_comb begin
        q_nxt = q_r;
        if (ce) begin
            if (pins_q2.strobe == pins_q3.strobe) begin
                q_nxt.strobe_lvl = pins_q3.strobe;
            end
            if (pins_q2.pwr_n == pins_q3.pwr_n) begin
                q_nxt.pwr_lvl = pins_q3.pwr_n;
            end

            // Strobe period measured in clk cycles
            if (rise) begin
                q_nxt.period = q_r.pcnt;
                q_nxt.pcnt = 8'h01;
            end else if (q_r.pcnt != PCNT_MAX) begin
                q_nxt.pcnt = q_r.pcnt + 8'h01;
            end

            // Seven slots per period from a fractional accumulator
            if (rise) begin
                q_nxt.slot = SLOT_FIRST;
                q_nxt.acc = '0;
                for (int l = 0; l < LANES; l++) begin
                    q_nxt.shreg[l] = pop ? lvs_lane_bits(fifo_dout, l) : '1;
                end
            end else if (q_r.slot != SLOT_LAST) begin
                if (acc_sum >= q_r.period) begin
                    q_nxt.slot = q_r.slot + 3'h1;
                    q_nxt.acc = acc_sum - q_r.period;
                    for (int l = 0; l < LANES; l++) begin
                        q_nxt.shreg[l] = {q_r.shreg[l][SLOTS-2:0], 1'b1};
                    end
                end else begin
                    q_nxt.acc = acc_sum;
                end
            end

            // Lock acquisition
            case (q_r.st)
                ST_DOWN: begin
                    q_nxt.lock_cnt = '0;
                    if (q_r.pwr_lvl) begin
                        q_nxt.st = ST_ACQ;
                    end
                end
                ST_ACQ: begin
                    if (!q_r.pwr_lvl) begin
                        q_nxt.st = ST_DOWN;
                    end else if (q_r.pcnt == PCNT_MAX || q_r.period == '0) begin
                        q_nxt.lock_cnt = '0;
                    end else if (q_r.lock_cnt == LOCK_CNT_W'(LOCK_CYCLES - 1)) begin
                        q_nxt.st = ST_LOCK;
                    end else begin
                        q_nxt.lock_cnt = q_r.lock_cnt + 1'b1;
                    end
                end
                ST_LOCK: begin
                    if (!q_r.pwr_lvl) begin
                        q_nxt.st = ST_DOWN;
                    end else if (q_r.pcnt == PCNT_MAX) begin
                        q_nxt.st = ST_ACQ;
                        q_nxt.lock_cnt = '0;
                    end
                end
                default: begin
                    q_nxt.st = ST_DOWN;
                    q_nxt.lock_cnt = '0;
                end
            endcase

            // Output stage
            for (int l = 0; l < LANES; l++) begin
                q_nxt.lane[l] = (q_nxt.st == ST_LOCK) ? q_nxt.shreg[l][SLOTS-1] : 1'b1;
            end
            q_nxt.fclk = (q_nxt.slot < FCLK_HIGH_SLOTS);
            q_nxt.oe = q_nxt.pwr_lvl;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q_r <= '{st: ST_DOWN, slot: SLOT_LAST, shreg: '1, lane: '1, default: '0};
        end else begin
            q_r <= q_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    always_comb begin
        lvds_out.lane_p = q_r.lane;
        lvds_out.lane_n = ~q_r.lane;
        lvds_out.clk_p = q_r.fclk;
        lvds_out.clk_n = ~q_r.fclk;
        lvds_out.oe = q_r.oe;
    end

    assign word_ready = fifo_in_ready;
    assign pll_locked = (q_r.st == ST_LOCK);

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n || !ce);

    sequence s_pin_low;
        !power_down_n [*5];
    endsequence

    sequence s_frame_load;
        rise && pop;
    endsequence

    a_pd_tristate: assert property (s_pin_low |-> ##1 !lvds_out.oe)
        else $error("outputs still enabled after power-down");
    a_pd_delay: assert property ($fell(q_r.pwr_lvl) |-> ##[1:2] !lvds_out.oe)
        else $error("power-down too slow");
    a_lane_map: assert property (s_frame_load |=> (q_r.shreg[0] == $past(fifo_dout[6:0])
        && q_r.shreg[1] == $past(fifo_dout[13:7]) && q_r.shreg[2] == $past(fifo_dout[20:14])))
        else $error("lane bit mapping wrong");
    a_slot_start: assert property (rise |=> q_r.slot == SLOT_FIRST ##1 q_r.slot <= 3'h1)
        else $error("frame did not start at slot zero");
    a_slot_step: assert property (!rise |=> (q_r.slot == $past(q_r.slot)
        || q_r.slot == $past(q_r.slot) + 3'h1) && q_r.slot <= SLOT_LAST)
        else $error("slot sequence broken");
    a_fwd_phase: assert property ($rose(lvds_out.clk_p) |-> $past(rise))
        else $error("forwarded clock rose away from frame start");
    a_lock_gate: assert property (!pll_locked |-> ##1 (lvds_out.lane_p == 3'h7 || pll_locked))
        else $error("lanes driven before lock");
    a_lock_time: assert property ($rose(pll_locked) |-> $past(q_r.lock_cnt) == LOCK_CNT_W'(LOCK_CYCLES - 1))
        else $error("locked before lock time");
    a_one_push: assert property (push |=> !push)
        else $error("two captures in one strobe period");
    a_empty_frame: assert property ((rise && !pop) |=> q_r.shreg == '1)
        else $error("empty frame not sent high");
endmodule

// ### dv/lvs_rx_model.sv
// Behavioural receiver for the three serial lanes and the forwarded clock.
// Assumes eight clk cycles per strobe period; released lines arrive as Z.
`timescale 1ns/1ps
module lvs_rx_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [lvs_pkg::LANES-1:0] lane,
    input wire logic fclk,
    output logic [lvs_pkg::WORD_W-1:0] rx_word,
    output logic rx_valid
);
    import lvs_pkg::*;
    logic fclk_r;
    logic [3:0] cnt_r;
    logic [SLOTS-1:0] sr_r [LANES];

    // ****************************************
    // Frame capture
    // ****************************************
    always @(posedge clk) begin
        rx_valid <= 1'b0;
        fclk_r <= fclk;
        if (!rst_n) begin
            cnt_r <= 4'h0;
        end else if (fclk === 1'b1 && fclk_r !== 1'b1) begin
            cnt_r <= 4'h1;
        end else if (cnt_r != 4'h0) begin
            for (int l = 0; l < LANES; l++) begin
                sr_r[l] <= {sr_r[l][SLOTS-2:0], lane[l]};
            end
            cnt_r <= (cnt_r == 4'h7) ? 4'h0 : cnt_r + 4'h1;
            if (cnt_r == 4'h7) begin
                rx_valid <= 1'b1;
            end
        end
    end
    assign rx_word = {sr_r[2], sr_r[1], sr_r[0]};
endmodule

// ### dv/tb_lvs_serializer.sv
// Self-checking bench of the serializer with a receiver model on the lanes.
// Assumes a 160 ns strobe made from clk and a shortened lock count.
`timescale 1ns/1ps
module tb_lvs_serializer;
    import lvs_pkg::*;
    localparam int LOCK_N = 50;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic strobe = 1'b0;
    logic pwr_n = 1'b1;
    logic [WORD_W-1:0] word_in = 21'h0;
    logic [WORD_W-1:0] flt = 21'h0;
    logic [WORD_W-1:0] next_word = 21'h0;
    logic [WORD_W-1:0] next_flt = 21'h0;
    logic [WORD_W-1:0] rx_word;
    lvs_lvds_s lvds;
    logic word_ready;
    logic pll_locked;
    logic rx_valid;
    int fail_count = 0;
    int num_checks = 0;
    int cyc = 0;
    int sc = 0;
    int rise_cnt = 0;
    int got = 0;
    int lat_ref = -1;
    bit track = 1'b0;
    int sent [logic [WORD_W-1:0]];
    wire [LANES-1:0] lane_w = lvds.oe ? lvds.lane_p : 3'hZ;
    wire fclk_w = lvds.oe ? lvds.clk_p : 1'bz;

    always #10 clk = ~clk;

    lvs_serializer #(.LOCK_CYCLES(LOCK_N)) dut (
        .clk(clk), .rst_n(rst_n), .ce(1'b1), .strobe_clock_in(strobe),
        .power_down_n(pwr_n), .parallel_word_in(word_in), .parallel_word_float(flt),
        .lvds_out(lvds), .word_ready(word_ready), .pll_locked(pll_locked)
    );

    lvs_rx_model rx (
        .clk(clk), .rst_n(rst_n), .lane(lane_w), .fclk(fclk_w), .rx_word(rx_word), .rx_valid(rx_valid)
    );

    // ****************************************
    // Compare and report
    // ****************************************
    task automatic check_bits(input logic [WORD_W-1:0] got_v, input logic [WORD_W-1:0] exp_v);
        num_checks++;
        if (got_v !== exp_v) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got_v, exp_v);
        end
    endtask

    task automatic check_int(input int got_v, input int exp_v);
        num_checks++;
        if (got_v != exp_v) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got_v, exp_v);
        end
    endtask

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ****************************************
    // Strobe, word pins and frame checks
    // ****************************************
    always @(posedge clk) begin
        if (rx_valid === 1'b1 && sent.exists(rx_word)) begin
            if (lat_ref < 0) begin
                lat_ref = rise_cnt - sent[rx_word];
            end
            check_int(rise_cnt - sent[rx_word], lat_ref);
            sent.delete(rx_word);
            got++;
        end
        if (lvds.oe === 1'b1) begin
            check_bits({17'h0, lvds.clk_n, lvds.lane_n}, {17'h0, ~lvds.clk_p, ~lvds.lane_p});
        end
        if (sc == 0) begin
            strobe <= 1'b1;
            rise_cnt++;
            if (track && (word_in | flt) != 21'h0) begin
                sent[word_in | flt] = rise_cnt;
            end
        end
        if (sc == 4) begin
            strobe <= 1'b0;
            word_in <= next_word;
            flt <= next_flt;
        end
        sc = (sc + 1) % 8;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            fail_count++;
            print_verdict();
        end
    end

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic wait_lock(input int bound);
        for (int i = 0; i < bound && pll_locked !== 1'b1; i++) begin
            @(posedge clk);
            #1;
            if (pll_locked !== 1'b1 && lvds.oe === 1'b1) begin
                check_bits({18'h0, lvds.lane_p}, 21'h000007);
            end
        end
        check_bits({19'h0, pll_locked, lvds.oe}, 21'h000003);
        repeat (32) @(posedge clk);
    endtask

    task automatic stream(input int base, input int step, input int n, input logic [WORD_W-1:0] mask);
        logic [6:0] v;
        got = 0;
        lat_ref = -1;
        track = 1'b1;
        for (int k = 0; k < n; k++) begin
            v = 7'(base + k * step);
            next_word <= {v ^ 7'h55, ~v, v};
            next_flt <= mask;
            repeat (8) @(posedge clk);
        end
        next_word <= 21'h0;
        next_flt <= 21'h0;
        for (int i = 0; i < (n + 24) * 8 && got < n; i++) begin
            @(posedge clk);
        end
        track = 1'b0;
        sent.delete();
        check_int(got, n);
    endtask

    task automatic power_cycle();
        check_bits({20'h0, word_ready}, 21'h000001);
        pwr_n <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
        check_bits({18'h0, lvds.oe, fclk_w, lane_w[0]}, {18'h0, 3'b0ZZ});
        repeat (160) @(posedge clk);
        #1;
        check_bits({19'h0, word_ready, lvds.oe}, 21'h000000);
        pwr_n <= 1'b1;
        wait_lock(600);
    endtask

    initial begin
        repeat (10) @(posedge clk);
        #1;
        check_bits({12'h0, lvds}, 21'h0001C2);
        check_bits({20'h0, word_ready}, 21'h000001);
        @(posedge clk);
        rst_n <= 1'b1;
        wait_lock(400);
        stream(1, 1, 16, 21'h0);
        stream(16, 16, 4, 21'h1F0F0F);
        power_cycle();
        stream(40, 1, 20, 21'h0);
        print_verdict();
    end
endmodule
